// File: rtl/i2csp_pkg.sv
// Purpose: Shared constants and types of the two-wire register port.
// Assumes: Seven-bit register index, eight-bit register data.
// Notes: State codes are one-hot.
package i2csp_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // Own seven-bit bus address; first byte reads 8'hBE for writes, 8'hBF for reads
  localparam logic [6:0] SLAVE_ADDR = 7'h5F;
  // Top five bits of a high-speed master code
  localparam logic [4:0] HS_CODE_TOP = 5'h01;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Reset levels of the link-side synchroniser lanes: {ack toggle, mode, sda, scl}
  localparam logic [3:0] LINK_SYNC_RESET = 4'h7;

  typedef enum logic [9:0] {
    S_IDLE      = 10'h001,
    S_ADDR      = 10'h002,
    S_ADDR_ACK  = 10'h004,
    S_SUB       = 10'h008,
    S_SUB_ACK   = 10'h010,
    S_WDATA     = 10'h020,
    S_WDATA_ACK = 10'h040,
    S_RFETCH    = 10'h080,
    S_RDATA     = 10'h100,
    S_RACK      = 10'h200
  } i2csp_state_t;

endpackage : i2csp_pkg

// File: rtl/i2csp_sync.sv
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: Output follows only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module i2csp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      q_o <= RESET_VAL;
    end else if (en_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q_o[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule : i2csp_sync
`default_nettype wire

// File: rtl/i2csp_top.sv
// Purpose: Two-wire bus slave giving a bus master access to 8-bit internal registers.
// Assumes: Bus pins are open-drain; link_clk_i oversamples the bus well above its bit rate.
// Notes: Bus engine on link_clk_i, register strobes on clk_i, joined by a toggle handshake.
//
// Contract
// - Port works only while mode select is high or floating.
// - Works at fast-mode and standard-mode clock rates.
// - Data falling while clock high is a start; bus busy, byte restarts.
// - First byte holds seven address bits then direction; match selects.
// - Own address is 1011111, first byte BEh write, BFh read.
// - Transmitter releases data in ack slot; receiver holds it low.
// - Address, sub-address and every written byte are acknowledged.
// - Sub-address low seven bits index register, top bit enables increment.
// - With increment set, address advances after each data byte; the port skips it after a read byte the master leaves unacked.
// - Write is address, sub-address, data bytes, each acked, then stop.
// - Read bytes go out until master withholds ack; then release.
// - Bytes are eight bits, most significant first, unlimited count.
// - Receiver may hold clock low to stall; master waits.
// - Slave refusing its address leaves data high in the ack slot.
// - Data rising while clock high is a stop; return to idle.
// - Master code 00001XXX is never acknowledged.
// - High-speed mode lasts across repeated starts until a stop.
`timescale 1ns/1ps
`default_nettype none
module i2csp_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  input wire logic mode_sel_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic bus_busy_o,
  output logic hs_mode_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [i2csp_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [i2csp_pkg::DATA_W-1:0] reg_wdata_o,
  input wire logic [i2csp_pkg::DATA_W-1:0] reg_rdata_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Link-side synchronisers

  logic ce_f;
  logic scl_f;
  logic sda_f;
  logic mode_f;
  logic ack_f;
  logic ack_tog;
  logic [i2csp_pkg::DATA_W-1:0] rdata_x;

  // Clock enable is never frozen by itself, or it could not wake up again
  i2csp_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_ce_sync (
    .clk_i(link_clk_i),
    .reset_i(reset_i),
    .en_i(1'b1),
    .d_i(ce_i),
    .q_o(ce_f)
  );

  // Oversampled far above 400 kHz, so fast and standard mode both resolve
  i2csp_sync #(.WIDTH(4), .RESET_VAL(i2csp_pkg::LINK_SYNC_RESET)) u_link_sync (
    .clk_i(link_clk_i),
    .reset_i(reset_i),
    .en_i(ce_f),
    .d_i({ack_tog, mode_sel_i, sda_i, scl_i}),
    .q_o({ack_f, mode_f, sda_f, scl_f})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions

  logic scl_q_reg;
  logic sda_q_reg;

  wire scl_rise = scl_f && !scl_q_reg;
  wire scl_fall = !scl_f && scl_q_reg;
  wire start_det = scl_f && scl_q_reg && sda_q_reg && !sda_f;
  wire stop_det = scl_f && scl_q_reg && !sda_q_reg && sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine state

  i2csp_pkg::i2csp_state_t state_reg, state_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [6:0] addr_reg, addr_next;
  logic inc_reg, inc_next;
  logic rw_reg, rw_next;
  logic hs_reg, hs_next;
  logic busy_reg, busy_next;
  logic req_tog_reg, req_tog_next;
  logic req_write_reg, req_write_next;
  logic [6:0] req_addr_reg, req_addr_next;
  logic [7:0] req_data_reg, req_data_next;
  logic sda_low_next;
  logic scl_low_next;

  wire byte_done = (bitcnt_reg == i2csp_pkg::BYTE_BITS);
  wire addr_hit = (shift_reg[7:1] == i2csp_pkg::SLAVE_ADDR);
  wire hs_code = (shift_reg[7:3] == i2csp_pkg::HS_CODE_TOP);
  wire pending = (req_tog_reg != ack_f);
  wire [6:0] addr_step = addr_reg + {6'h00, inc_reg};
  wire in_ack = (state_next == i2csp_pkg::S_ADDR_ACK) || (state_next == i2csp_pkg::S_SUB_ACK)
                || (state_next == i2csp_pkg::S_WDATA_ACK);

  always_comb begin
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    inc_next = inc_reg;
    rw_next = rw_reg;
    hs_next = hs_reg;
    busy_next = busy_reg;
    req_tog_next = req_tog_reg;
    req_write_next = req_write_reg;
    req_addr_next = req_addr_reg;
    req_data_next = req_data_reg;
    if (!mode_f) begin
      // Mode select low: port disabled, lines released
      state_next = i2csp_pkg::S_IDLE;
      busy_next = 1'b0;
      hs_next = 1'b0;
    end else if (start_det) begin
      // Start or repeated start restarts byte reception
      state_next = i2csp_pkg::S_ADDR;
      bitcnt_next = 4'h0;
      busy_next = 1'b1;
    end else if (stop_det) begin
      // Stop ends high-speed mode as well
      state_next = i2csp_pkg::S_IDLE;
      busy_next = 1'b0;
      hs_next = 1'b0;
    end else begin
      case (state_reg)
        i2csp_pkg::S_IDLE: begin
          state_next = i2csp_pkg::S_IDLE;
        end
        i2csp_pkg::S_ADDR, i2csp_pkg::S_SUB, i2csp_pkg::S_WDATA: begin
          if (scl_rise && !byte_done) begin
            shift_next = {shift_reg[6:0], sda_f};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            bitcnt_next = 4'h0;
            if (state_reg == i2csp_pkg::S_ADDR) begin
              if (addr_hit) begin
                rw_next = shift_reg[0];
                state_next = i2csp_pkg::S_ADDR_ACK;
              end else begin
                // Foreign address or master code: stay released
                hs_next = hs_reg || hs_code;
                state_next = i2csp_pkg::S_IDLE;
              end
            end else if (state_reg == i2csp_pkg::S_SUB) begin
              addr_next = shift_reg[6:0];
              inc_next = shift_reg[7];
              state_next = i2csp_pkg::S_SUB_ACK;
            end else begin
              req_write_next = 1'b1;
              req_addr_next = addr_reg;
              req_data_next = shift_reg;
              req_tog_next = ~req_tog_reg;
              state_next = i2csp_pkg::S_WDATA_ACK;
            end
          end
        end
        i2csp_pkg::S_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              req_write_next = 1'b0;
              req_addr_next = addr_reg;
              req_tog_next = ~req_tog_reg;
              state_next = i2csp_pkg::S_RFETCH;
            end else begin
              state_next = i2csp_pkg::S_SUB;
            end
          end
        end
        i2csp_pkg::S_SUB_ACK: begin
          if (scl_fall) begin
            state_next = i2csp_pkg::S_WDATA;
          end
        end
        i2csp_pkg::S_WDATA_ACK: begin
          if (scl_fall && !pending) begin
            addr_next = addr_step;
            state_next = i2csp_pkg::S_WDATA;
          end
        end
        i2csp_pkg::S_RFETCH: begin
          if (!pending) begin
            shift_next = rdata_x;
            bitcnt_next = 4'h0;
            state_next = i2csp_pkg::S_RDATA;
          end
        end
        i2csp_pkg::S_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_reg == i2csp_pkg::LAST_BIT) begin
              state_next = i2csp_pkg::S_RACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b1};
              bitcnt_next = bitcnt_reg + 4'h1;
            end
          end
        end
        i2csp_pkg::S_RACK: begin
          if (scl_rise) begin
            shift_next[0] = sda_f;
          end else if (scl_fall) begin
            if (!shift_reg[0]) begin
              addr_next = addr_step;
              req_write_next = 1'b0;
              req_addr_next = addr_step;
              req_tog_next = ~req_tog_reg;
              state_next = i2csp_pkg::S_RFETCH;
            end else begin
              state_next = i2csp_pkg::S_IDLE;
            end
          end
        end
        default: begin
          state_next = i2csp_pkg::S_IDLE;
        end
      endcase
    end
    // Pull data low in own ack slots and for zero bits of a read byte
    sda_low_next = in_ack || ((state_next == i2csp_pkg::S_RDATA) && !shift_next[7]);
    // Hold the clock while an access is pending, plus one read setup cycle
    scl_low_next = ((req_tog_next != ack_f) || (state_reg == i2csp_pkg::S_RFETCH)) && mode_f;
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      state_reg <= i2csp_pkg::S_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= 7'h00;
      inc_reg <= 1'b0;
      rw_reg <= 1'b0;
      hs_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (ce_f) begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      inc_reg <= inc_next;
      rw_reg <= rw_next;
      hs_reg <= hs_next;
      busy_reg <= busy_next;
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_tog_reg <= 1'b0;
      req_write_reg <= 1'b0;
      req_addr_reg <= 7'h00;
      req_data_reg <= 8'h00;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b1;
      scl_oe_o <= 1'b0;
      scl_o <= 1'b1;
      bus_busy_o <= 1'b0;
      hs_mode_o <= 1'b0;
    end else if (ce_f) begin
      req_tog_reg <= req_tog_next;
      req_write_reg <= req_write_next;
      req_addr_reg <= req_addr_next;
      req_data_reg <= req_data_next;
      sda_oe_o <= sda_low_next;
      sda_o <= !sda_low_next;
      scl_oe_o <= scl_low_next;
      scl_o <= !scl_low_next;
      bus_busy_o <= busy_next;
      hs_mode_o <= hs_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access on the system clock

  i2csp_xfer u_xfer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .req_tog_i(req_tog_reg),
    .req_write_i(req_write_reg),
    .req_addr_i(req_addr_reg),
    .req_wdata_i(req_data_reg),
    .reg_rdata_i(reg_rdata_i),
    .ack_tog_o(ack_tog),
    .rdata_o(rdata_x),
    .reg_wr_o(reg_wr_o),
    .reg_rd_o(reg_rd_o),
    .reg_addr_o(reg_addr_o),
    .reg_wdata_o(reg_wdata_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  mode_off_release_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (ce_f && !mode_f) |=> (!sda_oe_o && (state_reg == i2csp_pkg::S_IDLE)))
    else $error("port not released while mode select is low");

  start_restart_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (ce_f && mode_f && start_det) |=>
      (state_reg == i2csp_pkg::S_ADDR) && (bitcnt_reg == 4'h0) && bus_busy_o)
    else $error("start did not restart address reception");

  addr_match_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (ce_f && mode_f && !start_det && !stop_det && state_reg == i2csp_pkg::S_ADDR
     && byte_done && scl_fall)
    |=> ((state_reg == i2csp_pkg::S_ADDR_ACK) == ($past(shift_reg[7:1]) == i2csp_pkg::SLAVE_ADDR)))
    else $error("address decision disagrees with own address");

  ack_drive_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (state_reg == i2csp_pkg::S_ADDR_ACK || state_reg == i2csp_pkg::S_SUB_ACK
     || state_reg == i2csp_pkg::S_WDATA_ACK) |-> (sda_oe_o && !sda_o))
    else $error("ack slot not driven low");

  sub_capture_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (ce_f && $rose(state_reg == i2csp_pkg::S_SUB_ACK))
    |-> (addr_reg == $past(shift_reg[6:0])) && (inc_reg == $past(shift_reg[7])))
    else $error("sub-address not split into index and increment");

  auto_inc_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (ce_f && mode_f && !start_det && !stop_det && state_reg == i2csp_pkg::S_WDATA_ACK
     && scl_fall && !pending)
    |=> (addr_reg == 7'($past(addr_reg) + {6'h00, $past(inc_reg)})))
    else $error("register index not advanced by increment bit");

  hs_code_nack_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (ce_f && mode_f && !start_det && !stop_det && state_reg == i2csp_pkg::S_ADDR
     && byte_done && scl_fall && hs_code)
    |=> (!sda_oe_o && hs_mode_o) ##1 !sda_oe_o)
    else $error("master code was acknowledged");

  stop_idle_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (ce_f && mode_f && stop_det && !start_det)
    |=> ((state_reg == i2csp_pkg::S_IDLE) && !sda_oe_o && !bus_busy_o && !hs_mode_o))
    else $error("stop did not return port to idle");

  stretch_hold_a: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (ce_f && mode_f && $changed(req_tog_reg)) |-> scl_oe_o)
    else $error("clock not held during register access");

endmodule : i2csp_top
`default_nettype wire

// File: rtl/i2csp_xfer.sv
// Purpose: System-clock end of the register access handshake.
// Assumes: Request fields stay stable while the toggle differs from the answer toggle.
// Notes: Read data is sampled one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module i2csp_xfer (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic req_tog_i,
  input wire logic req_write_i,
  input wire logic [i2csp_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [i2csp_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic [i2csp_pkg::DATA_W-1:0] reg_rdata_i,
  output logic ack_tog_o,
  output logic [i2csp_pkg::DATA_W-1:0] rdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [i2csp_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [i2csp_pkg::DATA_W-1:0] reg_wdata_o
);

  logic req_f;
  logic seen_reg;
  logic rd_wait_reg;
  wire new_req = (req_f != seen_reg) && !rd_wait_reg;

  i2csp_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_req_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .en_i(ce_i),
    .d_i(req_tog_i),
    .q_o(req_f)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seen_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      ack_tog_o <= 1'b0;
      rdata_o <= 8'h00;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_addr_o <= 7'h00;
      reg_wdata_o <= 8'h00;
    end else if (ce_i) begin
      reg_wr_o <= new_req && req_write_i;
      reg_rd_o <= new_req && !req_write_i;
      if (new_req) begin
        seen_reg <= req_f;
        reg_addr_o <= req_addr_i;
        reg_wdata_o <= req_wdata_i;
        rd_wait_reg <= !req_write_i;
        if (req_write_i) begin
          ack_tog_o <= ~ack_tog_o;
        end
      end else if (rd_wait_reg && !reg_rd_o) begin
        // Strobe has been out one cycle; the data is valid now
        rdata_o <= reg_rdata_i;
        rd_wait_reg <= 1'b0;
        ack_tog_o <= ~ack_tog_o;
      end
    end
  end

endmodule : i2csp_xfer
`default_nettype wire

// File: tb/i2csp_master_model.sv
// Purpose: Behavioural two-wire bus master driving the register port.
// Assumes: Both lines are open-drain with pull-ups; a released line reads high.
// Notes: q_ns is a quarter bit time; the bench may slow it at run time.
`timescale 1ns/1ps
`default_nettype none
module i2csp_master_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  int q_ns = 150;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Release the clock, then wait while a stretching receiver still holds it
  task automatic clk_high();
    int n;
    n = 0;
    scl_o = 1'b1;
    while (scl_i !== 1'b1 && n < 20000) begin
      #5;
      n++;
    end
  endtask : clk_high

  // A level that moves within the high phase is read as a released line
  task automatic clk_bit(input logic b, output logic r);
    sda_o = b;
    #(q_ns);
    clk_high();
    #(q_ns);
    r = sda_i;
    #(q_ns);
    if (sda_i !== r) r = 1'b1;
    scl_o = 1'b0;
    #(q_ns);
  endtask : clk_bit

  // Also serves as repeated start when the clock is low
  task automatic start();
    sda_o = 1'b1;
    #(q_ns);
    clk_high();
    #(q_ns);
    sda_o = 1'b0;
    #(q_ns);
    scl_o = 1'b0;
    #(q_ns);
  endtask : start

  task automatic stop();
    sda_o = 1'b0;
    #(q_ns);
    clk_high();
    #(q_ns);
    sda_o = 1'b1;
    #(q_ns);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, ack);
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, r);
  endtask : rbyte
endmodule : i2csp_master_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the two-wire register port.
// Assumes: Register file modelled here, answering one clk_i after the read strobe.
// Notes: Expected strobes are queued by the drivers and popped by a monitor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic mode_sel_i = 1'b1;
  logic [7:0] reg_rdata_i = 8'h00;
  logic scl_m, sda_m, scl_o, scl_oe_o, sda_o, sda_oe_o, bus_busy_o, hs_mode_o;
  logic reg_wr_o, reg_rd_o;
  logic [6:0] reg_addr_o;
  logic [7:0] reg_wdata_o;
  logic [7:0] mem [128];
  logic [7:0] shadow [128];
  logic [15:0] exp_q [$];
  int errors = 0;
  int n_compared = 0;
  int seed = 85067;
  wire scl_w;
  wire sda_w;

  // Open-drain wires with pull-ups; the device's level counts only while it drives
  assign scl_w = scl_m & (scl_oe_o ? scl_o : 1'b1);
  assign sda_w = sda_m & (sda_oe_o ? sda_o : 1'b1);

  always #2.5 clk_i = ~clk_i;
  initial begin
    #1.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end

  i2csp_top uut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .link_clk_i(link_clk_i),
    .mode_sel_i(mode_sel_i), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_busy_o(bus_busy_o),
    .hs_mode_o(hs_mode_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i));
  i2csp_master_model master (.scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_bus(input string name, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk_bus

  task automatic chk_strobe(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] register strobe expected %h seen %h", e, g);
    end
  endtask : chk_strobe

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Register file model; strobes are compared against the queued notes
  always @(posedge clk_i) begin
    if (reg_wr_o === 1'b1) mem[reg_addr_o] <= reg_wdata_o;
    reg_rdata_i <= mem[reg_addr_o];
    if (reg_wr_o === 1'b1 || reg_rd_o === 1'b1) begin
      if (exp_q.size() == 0) chk_strobe(16'hFFFF, {reg_wr_o, reg_addr_o, reg_wdata_o});
      else chk_strobe(exp_q.pop_front(), {reg_wr_o, reg_addr_o, reg_wr_o ? reg_wdata_o : 8'h00});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_seq(input logic [7:0] sub, input int n);
    logic a;
    logic [7:0] d;
    logic [6:0] idx;
    idx = sub[6:0];
    master.start();
    master.wbyte(8'hBE, a);
    chk_bus("write address ack", 8'h00, {7'h00, a});
    master.wbyte(sub, a);
    chk_bus("sub-address ack", 8'h00, {7'h00, a});
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      shadow[idx] = d;
      exp_q.push_back({1'b1, idx, d});
      master.wbyte(d, a);
      chk_bus("data ack", 8'h00, {7'h00, a});
      if (sub[7]) idx = idx + 7'h01;
    end
    master.stop();
  endtask : wr_seq

  task automatic rd_seq(input logic [7:0] sub, input int n);
    logic a;
    logic [7:0] d;
    logic [6:0] idx;
    idx = sub[6:0];
    master.start();
    master.wbyte(8'hBE, a);
    master.wbyte(sub, a);
    master.start();
    exp_q.push_back({1'b1 ^ 1'b1, idx, 8'h00});
    master.wbyte(8'hBF, a);
    chk_bus("read address ack", 8'h00, {7'h00, a});
    for (int i = 0; i < n; i++) begin
      if (i < n - 1) exp_q.push_back({1'b0, sub[7] ? idx + 7'h01 : idx, 8'h00});
      master.rbyte(i == n - 1, d);
      chk_bus("read data", shadow[idx], d);
      if (sub[7]) idx = idx + 7'h01;
    end
    master.stop();
    #300;
    chk_bus("data released", 8'h01, {7'h00, sda_w});
  endtask : rd_seq

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic a;
    logic r;
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'($random(seed));
      shadow[i] = mem[i];
    end
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    wr_seq(8'hFE, 3);
    $display("test write with increment and wrap done");
    master.q_ns = 625;
    wr_seq(8'h10, 2);
    master.q_ns = 150;
    $display("test fixed-index write at fast-mode rate done");
    rd_seq(8'hFE, 3);
    rd_seq(8'h10, 2);
    $display("test reads done");
    for (int k = 0; k < 3; k++) begin
      master.start();
      chk_bus("busy after start", 8'h01, {7'h00, bus_busy_o});
      master.wbyte(k == 0 ? 8'hBC : (k == 1 ? 8'h3F : 8'h5E), a);
      chk_bus("foreign address ack", 8'h01, {7'h00, a});
      master.wbyte(8'hBE, a);
      chk_bus("ignored byte ack", 8'h01, {7'h00, a});
      master.stop();
      #300;
      chk_bus("idle after stop", 8'h00, {7'h00, bus_busy_o});
    end
    $display("test foreign addresses done");
    master.start();
    master.wbyte(8'h0B, a);
    chk_bus("master code ack", 8'h01, {7'h00, a});
    master.start();
    master.wbyte(8'hBE, a);
    chk_bus("high-speed address ack", 8'h00, {7'h00, a});
    chk_bus("high-speed kept", 8'h01, {7'h00, hs_mode_o});
    master.stop();
    #300;
    chk_bus("high-speed ends", 8'h00, {7'h00, hs_mode_o});
    $display("test master code done");
    @(posedge clk_i);
    mode_sel_i <= 1'b0;
    #300;
    master.start();
    master.wbyte(8'hBE, a);
    chk_bus("disabled port ack", 8'h01, {7'h00, a});
    master.stop();
    @(posedge clk_i);
    mode_sel_i <= 1'b1;
    #300;
    $display("test mode select low done");
    master.start();
    master.wbyte(8'hBE, a);
    for (int i = 0; i < 3; i++) master.clk_bit(1'b0, r);
    wr_seq(8'h86, 2);
    rd_seq(8'h06, 1);
    $display("test restart in mid-byte done");
    chk_bus("pending strobes", 8'h00, 8'(exp_q.size()));
    results();
  end

  initial begin
    #480000;
    errors++;
    $display("Watchdog expired before the tests ended");
    results();
  end
endmodule : testbench
`default_nettype wire
